// ===== ctcp_cfg.svh
// constants of the calibration test command port
`ifndef CTCP_CFG_SVH
`define CTCP_CFG_SVH
`define CTCP_CMD_BITS     32
`define CTCP_RST_LOW_MIN  16
`define CTCP_NV_FIRST     7'h01
`define CTCP_DATA_W       16
`define CTCP_NVADDR_W     7
`define CTCP_REGADDR_W    3
`define CTCP_OPC_W        4
`define CTCP_REG_CFG      3'h0
`define CTCP_REG_SCALE    3'h1
`define CTCP_REG_GDRIFT1  3'h2
`define CTCP_REG_GDRIFT2  3'h3
`define CTCP_REG_OFFTRIM  3'h4
`define CTCP_REG_ODRIFT1  3'h5
`define CTCP_REG_ODRIFT2  3'h6
`define CTCP_REG_PEDESTAL 3'h7
`define CTCP_CFG_COARSE_LSB 0
`define CTCP_CFG_GAIN_LSB   3
`define CTCP_CFG_OPAMP      7
`define CTCP_CFG_TEMP_LSB   9
`define CTCP_CFG_REPEAT     15
`define CTCP_REG_RESET    16'h0000
`endif

// ===== ctcp_pkg.sv
// types of the calibration test command port
`include "ctcp_cfg.svh"
package ctcp_pkg;
    typedef enum logic [3:0] {
        OPC_IDLE      = 4'h0,
        OPC_REG_WRITE = 4'h1,
        OPC_BIT_SET   = 4'h2,
        OPC_ERASE     = 4'h4,
        OPC_CONV_OBS  = 4'h8,
        OPC_LOAD_OBS  = 4'hA,
        OPC_CONV_QUIET = 4'hC,
        OPC_LOAD_QUIET = 4'hE
    } ctcp_opc_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOW   = 2'b01,
        ST_SHIFT = 2'b11,
        ST_EXEC  = 2'b10
    } ctcp_state_t;
    typedef struct packed {
        logic [`CTCP_DATA_W-1:0]    data;
        logic                       pad_hi;
        logic [`CTCP_NVADDR_W-1:0]  nv_addr;
        logic                       pad_lo;
        logic [`CTCP_REGADDR_W-1:0] reg_addr;
        logic [`CTCP_OPC_W-1:0]     opcode;
    } ctcp_cmd_t;
endpackage : ctcp_pkg

// ===== ctcp_top.sv
// serial test command port: command shifter, coefficients, bit store
// ======================================================================
// How it works
// R01 - tester holds test select high and clocks the oscillator input
// R02 - command reset held low at least 16 clocks before each command
// R03 - rising edge of command reset starts a 32-bit word capture
// R04 - tester changes line on falling edges; device samples on rising
// R05 - word splits into data, store bit address, register address, opcode
// R06 - data and register address used by opcode 1, bit address by 2
// R07 - opcode 1 writes 16-bit data into the addressed register
// R08 - command reset low clears every coefficient register
// R09 - opcodes 8 and C start conversion from current registers
// R10 - opcodes A and E load registers from store, then convert
// R11 - 8 and A enable both serial outputs; C and E leave them off
// R12 - opcode 4 erases all 128 store bits to zero
// R13 - opcode 2 sets one store bit; nothing clears a single bit
// R14 - eight 16-bit two's complement registers
// R15 - register map: setup, scale, drifts, offsets, pedestal
// R16 - setup register bit layout with reserved bits kept
// R17 - setup bit 7 enables the spare amplifier
// R18 - last microcode step with setup bit 15 restarts conversion
// R19 - with test select low, coefficients come from the store
// R20 - store holds eight words from bit address 01 upward
// R21 - tester repeats bit set 375 times between idle commands; bench sets bit address 20 with a single repeat
// R22 - tester erases with idle, 375 erases, idle; at most 100
// R23 - reserved opcodes change nothing
`timescale 1ns/1ps
`include "ctcp_cfg.svh"
module ctcp_top
    import ctcp_pkg::*;
#(
    parameter int REG_W   = 16,
    parameter int REG_N   = 8,
    parameter int NV_BITS = 128
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        TEST_SEL_I,
    input  wire logic        CMD_RST_N_I,
    input  wire logic        SER_DATA_I,
    input  wire logic        DSP_S_BIT_I,
    input  wire logic        DSP_P_BIT_I,
    input  wire logic        DSP_LAST_STEP_I,
    input  wire logic [2:0]  REG_SEL_I,
    input  wire logic [6:0]  NV_SEL_I,
    output logic             SER_DATA_O,
    output logic             SER_DATA_OE_O,
    output logic             SERIAL_OUT_LINE_O,
    output logic             SERIAL_OUT_LINE_OE_O,
    output logic             CONV_START_O,
    output logic             CONV_FROM_STORE_O,
    output logic [15:0]      REG_DATA_O,
    output logic             NV_BIT_O,
    output logic [2:0]       COARSE_OFFSET_O,
    output logic [1:0]       AMP_GAIN_O,
    output logic             OPAMP_EN_O,
    output logic [2:0]       TEMP_OFFSET_O,
    output logic             REPEAT_O
);
    // the store mapping below assumes exactly this geometry
    if (REG_W != 16 || REG_N != 8 || NV_BITS != REG_W * REG_N) begin : g_chk
        $error("ctcp_top: geometry must be 8 words of 16 bits");
    end

    // ======================================================================
    // state and storage
    ctcp_state_t                   state;
    logic [4:0]                    low_cnt;
    logic [4:0]                    bit_cnt;
    logic [31:0]                   shift;
    ctcp_cmd_t                     cmd;
    logic [REG_N-1:0][REG_W-1:0]   coef;
    logic [NV_BITS-1:0]            nv;
    logic [REG_N-1:0][REG_W-1:0]   nv_words;
    logic                          exec;
    logic                          low_ok;

    assign cmd    = ctcp_cmd_t'(shift);
    assign exec   = (state == ST_EXEC) && TEST_SEL_I;
    assign low_ok = (low_cnt >= 5'(`CTCP_RST_LOW_MIN));

    // word w bit b sits at bit address 16w+b+1, wrapping to 00
    always_comb begin
        for (int w = 0; w < REG_N; w++) begin
            for (int b = 0; b < REG_W; b++) begin
                nv_words[w][b] = nv[7'(w * REG_W + b) + `CTCP_NV_FIRST]; // R20
            end
        end
    end

    // ======================================================================
    // command sequencer
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || !TEST_SEL_I) begin // R01
            state <= ST_IDLE;
        end else if (!CMD_RST_N_I) begin
            state <= ST_LOW;
        end else begin
            case (state)
                ST_LOW: begin
                    // too short a low pulse arms nothing
                    state <= low_ok ? ST_SHIFT : ST_IDLE; // R02 R03
                end
                ST_SHIFT: begin
                    if (bit_cnt == 5'(`CTCP_CMD_BITS - 1)) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || CMD_RST_N_I) begin
            low_cnt <= 5'h00;
        end else if (!low_ok) begin
            low_cnt <= low_cnt + 5'h01; // R02
        end
    end

    // msb first, so the opcode is the last nibble in
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || state != ST_SHIFT) begin
            bit_cnt <= 5'h00;
        end else begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            shift <= 32'h0000_0000;
        end else if (state == ST_SHIFT && CMD_RST_N_I) begin
            shift <= {shift[30:0], SER_DATA_I}; // R03 R04 R05
        end
    end

    // ======================================================================
    // coefficient registers
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            coef <= '0;
        end else if (!TEST_SEL_I) begin
            coef <= nv_words; // R19
        end else if (!CMD_RST_N_I) begin
            coef <= '0; // R08
        end else if (exec) begin
            case (cmd.opcode)
                OPC_REG_WRITE: begin
                    coef[cmd.reg_addr] <= cmd.data; // R06 R07 R14 R15
                end
                OPC_LOAD_OBS, OPC_LOAD_QUIET: begin
                    coef <= nv_words; // R10
                end
                default: begin
                    coef <= coef; // R23
                end
            endcase
        end
    end

    // ======================================================================
    // bit store; a set is instant here, the tester keeps the pump time
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            nv <= nv;
        end else if (exec && cmd.opcode == OPC_ERASE) begin
            nv <= '0; // R12 R22
        end else if (exec && cmd.opcode == OPC_BIT_SET) begin
            nv[cmd.nv_addr] <= 1'b1; // R06 R13 R21
        end
    end

    // ======================================================================
    // conversion start and serial outputs
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            CONV_START_O      <= 1'b0;
            CONV_FROM_STORE_O <= 1'b0;
        end else begin
            CONV_START_O <= (exec && cmd.opcode[3] && !cmd.opcode[0]) // R09
                || (DSP_LAST_STEP_I && coef[0][`CTCP_CFG_REPEAT]); // R18
            if (!TEST_SEL_I) begin
                CONV_FROM_STORE_O <= 1'b1; // R19
            end else if (exec && cmd.opcode[3] && !cmd.opcode[0]) begin
                CONV_FROM_STORE_O <= cmd.opcode[1]; // R10
            end
        end
    end

    // pins released while command reset is low so the tester can drive
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || !TEST_SEL_I || !CMD_RST_N_I) begin
            SER_DATA_OE_O        <= 1'b0;
            SERIAL_OUT_LINE_OE_O <= 1'b0;
        end else if (exec && cmd.opcode[3] && !cmd.opcode[0]) begin
            SER_DATA_OE_O        <= !cmd.opcode[2]; // R11
            SERIAL_OUT_LINE_OE_O <= !cmd.opcode[2]; // R11
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            SER_DATA_O        <= 1'b0;
            SERIAL_OUT_LINE_O <= 1'b0;
        end else begin
            SER_DATA_O        <= DSP_P_BIT_I;
            SERIAL_OUT_LINE_O <= DSP_S_BIT_I;
        end
    end

    // ======================================================================
    // setup decode and read-back
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            COARSE_OFFSET_O <= 3'h0;
            AMP_GAIN_O      <= 2'h0;
            OPAMP_EN_O      <= 1'b0;
            TEMP_OFFSET_O   <= 3'h0;
            REPEAT_O        <= 1'b0;
            REG_DATA_O      <= `CTCP_REG_RESET;
            NV_BIT_O        <= 1'b0;
        end else begin
            COARSE_OFFSET_O <= coef[0][`CTCP_CFG_COARSE_LSB +: 3]; // R16
            // bit 3 is the gain msb, so the pair is swapped
            AMP_GAIN_O      <= {coef[0][`CTCP_CFG_GAIN_LSB],
                                coef[0][`CTCP_CFG_GAIN_LSB + 1]}; // R16
            OPAMP_EN_O      <= coef[0][`CTCP_CFG_OPAMP]; // R17
            TEMP_OFFSET_O   <= coef[0][`CTCP_CFG_TEMP_LSB +: 3]; // R16
            REPEAT_O        <= coef[0][`CTCP_CFG_REPEAT];
            REG_DATA_O      <= coef[REG_SEL_I];
            NV_BIT_O        <= nv[NV_SEL_I];
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    chk_short_low: assert property ( // R02
        state == ST_LOW && CMD_RST_N_I && TEST_SEL_I && !low_ok
        |=> state == ST_IDLE) else $error("short reset pulse armed");
    // 33 edges back is the low-to-shift edge
    chk_word_len: assert property ( // R03
        state == ST_EXEC |-> $past(state, 33) == ST_LOW)
        else $error("command word not 32 bits");
    chk_reg_write: assert property ( // R07
        exec && cmd.opcode == OPC_REG_WRITE && CMD_RST_N_I
        |=> coef[$past(cmd.reg_addr)] == $past(cmd.data))
        else $error("register write lost");
    chk_reset_clear: assert property ( // R08
        TEST_SEL_I && !CMD_RST_N_I |=> coef == '0)
        else $error("registers not cleared");
    chk_load_store: assert property ( // R10
        exec && cmd.opcode == OPC_LOAD_OBS && CMD_RST_N_I
        |=> coef == $past(nv_words) && CONV_START_O)
        else $error("store load missing");
    chk_out_enable: assert property ( // R11
        exec && CMD_RST_N_I && cmd.opcode[3] && !cmd.opcode[0]
        |=> SER_DATA_OE_O == !$past(cmd.opcode[2]))
        else $error("output enable wrong");
    chk_erase_all: assert property ( // R12
        exec && cmd.opcode == OPC_ERASE |=> nv == '0)
        else $error("erase incomplete");
    chk_bit_only_set: assert property ( // R13
        (|($past(nv) & ~nv)) |-> $past(exec && cmd.opcode == OPC_ERASE))
        else $error("store bit cleared without erase");
    chk_repeat_conv: assert property ( // R18
        DSP_LAST_STEP_I && coef[0][`CTCP_CFG_REPEAT] |=> CONV_START_O)
        else $error("repeat did not restart");
    chk_reserved_opc: assert property ( // R23
        !DSP_LAST_STEP_I && exec && CMD_RST_N_I
        && cmd.opcode inside {4'h3, 4'h5, 4'h6, 4'h7,
        4'h9, 4'hB, 4'hD, 4'hF} |=> $stable(nv) && $stable(coef)
        && !CONV_START_O) else $error("reserved opcode acted");

    // decode, pin, store bit and sequencer checks
    chk_gain_order: assert property ( // R16
        AMP_GAIN_O[1] == $past(coef[0][`CTCP_CFG_GAIN_LSB]))
        else $error("gain select bits swapped");
    chk_opamp_en: assert property ( // R17
        OPAMP_EN_O == $past(coef[0][`CTCP_CFG_OPAMP]))
        else $error("spare amplifier enable wrong");
    chk_store_mode: assert property ( // R19
        !TEST_SEL_I |=> coef == $past(nv_words) && CONV_FROM_STORE_O)
        else $error("normal mode not using store");
    chk_quiet_pins: assert property ( // R11
        exec && CMD_RST_N_I && cmd.opcode inside {4'hC, 4'hE}
        |=> !SER_DATA_OE_O && !SERIAL_OUT_LINE_OE_O)
        else $error("quiet start enabled pins");
    chk_bit_set: assert property ( // R13
        exec && cmd.opcode == OPC_BIT_SET |=> nv[$past(cmd.nv_addr)] == 1'b1)
        else $error("store bit not set");
    chk_cmd_abort: assert property ( // R02
        TEST_SEL_I && !CMD_RST_N_I |=> state == ST_LOW)
        else $error("low reset did not rearm");
    chk_pins_released: assert property ( // R11
        !CMD_RST_N_I |=> !SER_DATA_OE_O && !SERIAL_OUT_LINE_OE_O)
        else $error("pins driven during reset");

    cov_reg_write: cover property (exec && cmd.opcode == OPC_REG_WRITE);
    cov_conv_obs: cover property (exec && cmd.opcode == OPC_CONV_OBS);
    cov_erase: cover property (exec && cmd.opcode == OPC_ERASE);
    cov_repeat: cover property (DSP_LAST_STEP_I && coef[0][`CTCP_CFG_REPEAT]);
    cov_store_mode: cover property (!TEST_SEL_I ##1 CONV_FROM_STORE_O);
endmodule : ctcp_top

// ===== ctcp_tester.sv
// tester model that drives the command port from the far side
`timescale 1ns/1ps
module ctcp_tester (
    input  wire logic clk_i,
    output logic      test_sel_o,
    output logic      cmd_rst_n_o,
    output logic      ser_o
);
    logic busy = 1'b0;
    initial begin
        test_sel_o  = 1'b1;
        cmd_rst_n_o = 1'b0;
        ser_o       = 1'b0;
    end
    // released line toggles so a stale bit never looks valid
    always @(negedge clk_i) if (!busy) ser_o <= ~ser_o;
    // ======================================================
    // one command: low pulse, then word msb first
    task automatic send(input logic [31:0] w, input int lows);
        busy = 1'b1;
        repeat (lows) @(negedge clk_i) cmd_rst_n_o = 1'b0;
        @(negedge clk_i) cmd_rst_n_o = 1'b1;
        for (int i = 31; i >= 0; i--) @(negedge clk_i) ser_o = w[i];
        @(posedge clk_i) busy = 1'b0;
    endtask : send
    // store write: idle, n repeats, idle with the same address
    task automatic pump(input logic [31:0] w, input int n);
        send({w[31:4], 4'h0}, 16);
        repeat (n) send(w, 16);
        send({w[31:4], 4'h0}, 16);
    endtask : pump
endmodule : ctcp_tester

// ===== ctcp_top_tb_top.sv
// self-checking bench of the calibration test command port
`timescale 1ns/1ps
module ctcp_top_tb_top;
    import ctcp_pkg::*;
    typedef struct packed {
        logic [2:0]  sel;
        logic [15:0] val;
    } ctcp_row_t;
    logic        clk = 1'b0, rst = 1'b1, last_step = 1'b0;
    logic        s_bit = 1'b0, p_bit = 1'b1;
    logic [2:0]  reg_sel = 3'h0, coarse, temp;
    logic [6:0]  nv_sel = 7'h00;
    logic [1:0]  gain;
    logic [15:0] reg_data;
    logic        tst_sel, tst_rst_n, tst_ser, ser_line, ser_o, ser_oe;
    logic        sol, sol_oe, start, from_store, nv_bit, opamp, rpt;
    logic [3:0]  cv_op [4] = '{4'hA, 4'hE, 4'h8, 4'hC};
    logic [3:0]  rsv_op [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB, 4'hD,
        4'hF};
    int          miscompares = 0, checks = 0, starts = 0, b;
    ctcp_row_t   rows [8] = '{'{3'h0, 16'h0895}, '{3'h1, 16'h8000},
        '{3'h2, 16'h7FFF}, '{3'h3, 16'h0001}, '{3'h4, 16'hFFFF},
        '{3'h5, 16'h1234}, '{3'h6, 16'hA5C3}, '{3'h7, 16'h7FFE}};
    assign ser_line = ser_oe ? ser_o : tst_ser;
    always #50 clk = ~clk;
    always @(posedge clk) if (start === 1'b1) starts++;
    ctcp_tester ctcp_tester_i (.clk_i(clk), .test_sel_o(tst_sel),
        .cmd_rst_n_o(tst_rst_n), .ser_o(tst_ser));
    ctcp_top ctcp_top_i (.CORE_CLK_I(clk), .SYS_RST_I(rst),
        .TEST_SEL_I(tst_sel), .CMD_RST_N_I(tst_rst_n),
        .SER_DATA_I(ser_line), .DSP_S_BIT_I(s_bit), .DSP_P_BIT_I(p_bit),
        .DSP_LAST_STEP_I(last_step), .REG_SEL_I(reg_sel),
        .NV_SEL_I(nv_sel), .SER_DATA_O(ser_o), .SER_DATA_OE_O(ser_oe),
        .SERIAL_OUT_LINE_O(sol), .SERIAL_OUT_LINE_OE_O(sol_oe),
        .CONV_START_O(start), .CONV_FROM_STORE_O(from_store),
        .REG_DATA_O(reg_data), .NV_BIT_O(nv_bit),
        .COARSE_OFFSET_O(coarse), .AMP_GAIN_O(gain), .OPAMP_EN_O(opamp),
        .TEMP_OFFSET_O(temp), .REPEAT_O(rpt));
    // ==========================================================
    // helpers
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // ends just after the edge where a command takes effect
    task automatic run(input logic [31:0] w, input int lows);
        ctcp_tester_i.send(w, lows);
        @(posedge clk);
        #10;
    endtask : run
    task automatic nvchk(input logic [6:0] a, input logic v);
        nv_sel = a;
        @(posedge clk);
        #10 cmp({15'h0000, nv_bit}, {15'h0000, v});
    endtask : nvchk
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        #10 rst = 1'b0;
        cmp({reg_data[12:0], start, ser_oe, sol_oe}, 16'h0000);
        foreach (rows[i]) begin
            reg_sel = rows[i].sel;
            run({rows[i].val, 8'hFF, 1'b0, rows[i].sel, 4'h1}, 16);
            @(posedge clk);
            #10 cmp(reg_data, rows[i].val);
            if (i == 0)
                cmp({coarse, gain, opamp, temp, rpt}, 10'h2B8);
        end
        run(32'h0000_0000, 16);
        cmp(reg_data, 16'h0000);
        reg_sel = 3'h2;
        run({16'hABCD, 8'h00, 1'b0, 3'h2, 4'h1}, 15);
        @(posedge clk);
        #10 cmp(reg_data, 16'h0000);
        ctcp_tester_i.pump(32'h0000_0004, 375);
        repeat (2) @(posedge clk);
        #10;
        for (int a = 0; a < 128; a++) nvchk(a[6:0], 1'b0);
        ctcp_tester_i.pump({16'h0000, 8'h11, 8'h02}, 375);
        ctcp_tester_i.pump({16'h0000, 8'h20, 8'h02}, 1);
        repeat (2) @(posedge clk);
        #10;
        nvchk(7'h11, 1'b1);
        nvchk(7'h20, 1'b1);
        nvchk(7'h12, 1'b0);
        reg_sel = 3'h1;
        b = starts;
        foreach (rsv_op[i]) begin
            run({16'hFFFF, 8'h12, 1'b0, 3'h1, rsv_op[i]}, 16);
            @(posedge clk);
            #10 cmp(reg_data, 16'h0000);
        end
        nvchk(7'h12, 1'b0);
        nvchk(7'h11, 1'b1);
        cmp(starts[15:0], b[15:0]);
        reg_sel = 3'h1;
        foreach (cv_op[i]) begin
            p_bit = cv_op[i][1];
            s_bit = ~cv_op[i][1];
            run({24'h000000, 4'h0, cv_op[i]}, 16);
            cmp({start, ser_oe, sol_oe, from_store},
                {1'b1, ~cv_op[i][2], ~cv_op[i][2], cv_op[i][1]});
            if (!cv_op[i][2]) cmp({ser_o, sol}, {p_bit, s_bit});
            @(posedge clk);
            #10 cmp(reg_data, cv_op[i][1] ? 16'h8001 : 16'h0000);
        end
        run({16'h8000, 8'h00, 1'b0, 3'h0, 4'h1}, 16);
        b = starts;
        last_step = 1'b1;
        @(posedge clk);
        #10 last_step = 1'b0;
        repeat (3) @(posedge clk);
        #10 cmp(starts[15:0], b[15:0] + 16'h0001);
        cmp({15'h0000, rpt}, 16'h0001);
        ctcp_tester_i.test_sel_o = 1'b0;
        repeat (3) @(posedge clk);
        #10 cmp({reg_data[14:0], from_store}, 16'h0003);
        wrap_up();
    end
endmodule : ctcp_top_tb_top
